// ===== hdl/nand_prot_defs.svh
// constants for the nand protection/otp host controller
// assumes a byte-wide async nand bus driven from one 20 MHz clock
`ifndef NAND_PROT_DEFS_SVH
`define NAND_PROT_DEFS_SVH
// ==========================================================
// command bytes
`define CMD_LOCK_QUERY   8'h7A
`define CMD_EN0          8'h4C
`define CMD_EN1          8'h03
`define CMD_EN2          8'h1D
`define CMD_EN3          8'h41
`define CMD_PROG_SETUP   8'h80
`define CMD_PROG_CONFIRM 8'h10
`define CMD_RESET        8'hFF
`define CMD_SET_FEATURE  8'hEF
`define CMD_READ_STATUS  8'h70
`define CMD_RAND_INPUT   8'h85
// ==========================================================
// feature and parameter values
`define FEAT_OTP_ADDR    8'h90
`define OTP_P1_EXIT      8'h00
`define OTP_P1_OPER      8'h01
`define OTP_P1_PROTECT   8'h03
`define OTP_PAGE_FIRST   8'h02
`define OTP_PAGE_LAST    8'h1F
`define GROUP_LAST       4'hB
`define OTP_PARTIAL_MAX  3'h4
// ==========================================================
// status byte fields
`define ST_READY_BIT     5
`define ST_FAIL_BIT      0
`define LOCK_FIELD_MSB   2
// ==========================================================
// bus timing: strobe phase length in ns and cycles at 50 ns
`define CLK_PERIOD_NS    50
`define STROBE_NS        50
`define STROBE_CYC       ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== hdl/nand_prot_pkg.sv
// types for the nand protection/otp host controller
// assumes the defs header supplies all numeric constants
package nand_prot_pkg;
   // ==========================================================
   // user operations
   typedef enum logic [2:0] {
      op_lock_query = 3'h0,  // read block protection state
      op_perm_prot  = 3'h1,  // permanent group protect
      op_otp_mode   = 3'h2,  // set otp mode via feature 90h
      op_otp_prog   = 3'h3,  // program otp bytes
      op_otp_lock   = 3'h4,  // protect otp area
      op_status     = 3'h5   // plain status read
   } op_kind_t;
   // request carried as one struct
   typedef struct packed {
      op_kind_t   kind;
      logic [7:0] arg0;   // block/page/group/p1 value
      logic [7:0] arg1;   // block high / column low
      logic [7:0] data;   // otp data byte
   } nand_req_t;
   // pin bundle toward the flash
   typedef struct packed {
      logic       ce_n;
      logic       cle;
      logic       ale;
      logic       we_n;
      logic       read_strobe_n;
   } nand_ctl_t;
endpackage : nand_prot_pkg

// ===== hdl/nand_prot_host.sv
// host controller for flash lock query, permanent protect and otp ops
// assumes flash pins synchronous to clock_i; rb_n_i low means busy
`include "nand_prot_defs.svh"
module nand_prot_host (
   input  wire logic                     clock_i,
   input  wire logic                     srst_i,
   input  wire nand_prot_pkg::nand_req_t req_i,      // operation request
   input  wire logic                     req_valid_i,
   output logic                          req_ready_o,
   output logic                          done_o,     // one-cycle pulse
   output logic [7:0]                    result_o,   // status / lock byte
   output logic                          error_o,    // refused or failed
   output nand_prot_pkg::nand_ctl_t      ctl_o,      // strobes to flash
   output logic [7:0]                    io_o,
   output logic                          io_oe_o,
   input  wire logic [7:0]               io_i,
   input  wire logic                     rb_n_i,
   output logic                          wp_n_o
);
   // ==========================================================
   // bus cycle kinds of the sequencer script
   typedef enum logic [1:0] {
      cy_cmd  = 2'h0,
      cy_addr = 2'h1,
      cy_data = 2'h2,
      cy_read = 2'h3
   } cyc_kind_t;
   // states, gray along idle->load->low->high->busy
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_load = 3'b001,
      st_low  = 3'b011,
      st_high = 3'b010,
      st_wait = 3'b110,
      st_done = 3'b111
   } state_t;
   // ==========================================================
   // registers
   state_t                  state_ff;      // sequencer
   nand_prot_pkg::nand_req_t req_ff;       // latched request
   logic [3:0]              step_ff;       // script index
   logic [3:0]              last_ff;       // last script index
   logic [1:0]              tmr_ff;        // strobe phase timer
   logic [7:0]              rdata_ff;      // captured byte
   logic [7:0]              otp_page_ff;   // last programmed otp page
   logic [2:0]              part_cnt_ff;   // partial programs this page
   logic                    otp_lock_ff;   // area known protected
   logic                    seen_busy_ff;  // busy seen after confirm or last feature byte
   // script entry decode for current step
   cyc_kind_t               cyc;
   logic [7:0]              cyc_byte;
   logic                    wait_busy;
   logic                    refuse;
   // ==========================================================
   // script: one cycle per step for each operation kind
   always_comb begin
      cyc       = cy_cmd;
      cyc_byte  = `CMD_RESET;
      wait_busy = 1'b0;
      case (req_ff.kind)
         nand_prot_pkg::op_lock_query: begin
            case (step_ff)
               4'h0: cyc_byte = `CMD_LOCK_QUERY;
               4'h1: begin
                  cyc      = cy_addr;
                  cyc_byte = {req_ff.arg0[7:6], 6'h00}; // invert low
               end
               4'h2: begin
                  cyc = cy_addr; cyc_byte = req_ff.arg1;
               end
               4'h3: begin
                  cyc = cy_addr; cyc_byte = 8'h00;
               end
               default: cyc = cy_read;
            endcase
         end
         nand_prot_pkg::op_perm_prot: begin
            // back-to-back, no stray cycle in between
            case (step_ff)
               4'h0: cyc_byte = `CMD_EN0;
               4'h1: cyc_byte = `CMD_EN1;
               4'h2: cyc_byte = `CMD_EN2;
               4'h3: cyc_byte = `CMD_EN3;
               4'h4: cyc_byte = `CMD_PROG_SETUP;
               4'h5, 4'h6, 4'h7, 4'h9: begin
                  cyc = cy_addr; cyc_byte = 8'h00;
               end
               4'h8: begin
                  cyc = cy_addr; cyc_byte = {4'h0, req_ff.arg0[3:0]};
               end
               4'hA: begin
                  cyc_byte = `CMD_PROG_CONFIRM; wait_busy = 1'b1;
               end
               4'hB: cyc_byte = `CMD_READ_STATUS;
               4'hC: cyc = cy_read;
               default: cyc_byte = `CMD_RESET; // leave mode
            endcase
         end
         nand_prot_pkg::op_otp_mode: begin
            case (step_ff)
               4'h0: cyc_byte = `CMD_SET_FEATURE;
               4'h1: begin
                  cyc = cy_addr; cyc_byte = `FEAT_OTP_ADDR;
               end
               4'h2: begin
                  cyc = cy_data; cyc_byte = req_ff.arg0;
               end
               default: begin
                  cyc = cy_data; cyc_byte = 8'h00;
                  wait_busy = (step_ff == 4'h5);
               end
            endcase
         end
         nand_prot_pkg::op_otp_prog, nand_prot_pkg::op_otp_lock: begin
            case (step_ff)
               4'h0: cyc_byte = `CMD_PROG_SETUP;
               4'h1: begin
                  cyc = cy_addr; cyc_byte = req_ff.arg1; // column low
               end
               4'h2: begin
                  cyc = cy_addr; cyc_byte = 8'h00; // column high
               end
               4'h3: begin
                  cyc = cy_addr; cyc_byte = req_ff.arg0; // page
               end
               4'h4, 4'h5: begin
                  cyc = cy_addr; cyc_byte = 8'h00;
               end
               4'h6: begin
                  cyc = cy_data; cyc_byte = req_ff.data;
               end
               4'h7: begin
                  cyc_byte = `CMD_PROG_CONFIRM; wait_busy = 1'b1;
               end
               4'h8: cyc_byte = `CMD_READ_STATUS;
               default: cyc = cy_read;
            endcase
         end
         default: begin
            case (step_ff)
               4'h0: cyc_byte = `CMD_READ_STATUS;
               default: cyc = cy_read;
            endcase
         end
      endcase
   end
   // ==========================================================
   // refusal checks made at request time
   always_comb begin
      refuse = 1'b0;
      case (req_i.kind)
         nand_prot_pkg::op_perm_prot:
            refuse = (req_i.arg0[3:0] > `GROUP_LAST);
         nand_prot_pkg::op_otp_prog:
            // range, ascending order, partial limit
            refuse = (req_i.arg0 < `OTP_PAGE_FIRST)
                  || (req_i.arg0 > `OTP_PAGE_LAST)
                  || (req_i.arg0 < otp_page_ff)
                  || ((req_i.arg0 == otp_page_ff)
                      && (part_cnt_ff >= `OTP_PARTIAL_MAX));
         nand_prot_pkg::op_otp_lock:
            refuse = (req_i.arg0 != 8'h00) || (req_i.data != 8'h00);
         default: refuse = 1'b0;
      endcase
   end
   // ==========================================================
   // sequencer
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         state_ff     <= st_idle;
         step_ff      <= 4'h0;
         last_ff      <= 4'h0;
         tmr_ff       <= 2'h0;
         seen_busy_ff <= 1'b0;
      end else begin
         case (state_ff)
            st_idle: begin
               if (req_valid_i && !refuse) begin
                  state_ff <= st_load;
                  step_ff  <= 4'h0;
                  case (req_i.kind)
                     nand_prot_pkg::op_lock_query: last_ff <= 4'h4;
                     nand_prot_pkg::op_perm_prot:  last_ff <= 4'hD;
                     nand_prot_pkg::op_otp_mode:   last_ff <= 4'h5;
                     nand_prot_pkg::op_status:     last_ff <= 4'h1;
                     default:                      last_ff <= 4'h9;
                  endcase
               end
            end
            st_load: begin
               // setup phase: pins settle before strobe drops
               tmr_ff   <= 2'(`STROBE_CYC);
               state_ff <= st_low;
            end
            st_low: begin
               if (tmr_ff > 2'h1) begin
                  tmr_ff <= tmr_ff - 2'h1;
               end else begin
                  tmr_ff   <= 2'(`STROBE_CYC);
                  state_ff <= st_high;
               end
            end
            st_high: begin
               if (tmr_ff > 2'h1) begin
                  tmr_ff <= tmr_ff - 2'h1;
               end else if (wait_busy) begin
                  seen_busy_ff <= 1'b0;
                  state_ff     <= st_wait;
               end else if (step_ff == last_ff) begin
                  state_ff <= st_done;
               end else begin
                  step_ff  <= step_ff + 4'h1;
                  state_ff <= st_load;
               end
            end
            st_wait: begin
               // wait out program busy time, short refusal busy or feature busy
               if (!rb_n_i) begin
                  seen_busy_ff <= 1'b1;
               end else if (seen_busy_ff && step_ff == last_ff) begin
                  // busy on the last step ends the op, no extra cycles
                  state_ff <= st_done;
               end else if (seen_busy_ff) begin
                  step_ff  <= step_ff + 4'h1;
                  state_ff <= st_load;
               end
            end
            st_done:  state_ff <= st_idle;
            default:  state_ff <= st_idle;
         endcase
      end
   end
   // ==========================================================
   // request latch and captured read byte
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         req_ff   <= '0;
         rdata_ff <= 8'h00;
      end else begin
         if (state_ff == st_idle && req_valid_i) req_ff <= req_i;
         // sample while the strobe stands low; byte valid since its fall
         if (state_ff == st_high && tmr_ff == 2'h1 && cyc == cy_read)
            rdata_ff <= io_i;
      end
   end
   // ==========================================================
   // otp bookkeeping; device does the real refusal, we mirror it
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         otp_page_ff <= 8'h00;
         part_cnt_ff <= 3'h0;
         otp_lock_ff <= 1'b0;
      end else if (state_ff == st_done && !rdata_ff[`ST_FAIL_BIT]) begin
         if (req_ff.kind == nand_prot_pkg::op_otp_prog) begin
            otp_page_ff <= req_ff.arg0;
            part_cnt_ff <= (req_ff.arg0 == otp_page_ff)
                         ? part_cnt_ff + 3'h1 : 3'h1;
         end
         if (req_ff.kind == nand_prot_pkg::op_otp_lock)
            otp_lock_ff <= 1'b1;
      end
   end
   // ==========================================================
   // outputs, all registered
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         ctl_o       <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0,
                          we_n: 1'b1, read_strobe_n: 1'b1};
         io_o        <= 8'h00;
         io_oe_o     <= 1'b0;
         req_ready_o <= 1'b0;
         done_o      <= 1'b0;
         result_o    <= 8'h00;
         error_o     <= 1'b0;
         wp_n_o      <= 1'b0;
      end else begin
         wp_n_o      <= 1'b1; // keep write-protect released
         req_ready_o <= (state_ff == st_idle) && !req_valid_i;
         done_o      <= 1'b0;
         ctl_o.ce_n  <= (state_ff == st_idle) || (state_ff == st_done);
         ctl_o.cle   <= (state_ff != st_idle) && (cyc == cy_cmd);
         ctl_o.ale   <= (state_ff != st_idle) && (cyc == cy_addr);
         ctl_o.we_n  <= !((state_ff == st_low) && (cyc != cy_read));
         ctl_o.read_strobe_n <= !((state_ff == st_low) && (cyc == cy_read));
         io_oe_o     <= (state_ff == st_load || state_ff == st_low
                         || state_ff == st_high) && (cyc != cy_read);
         io_o        <= cyc_byte;
         if (state_ff == st_idle && req_valid_i && refuse) begin
            done_o  <= 1'b1;
            error_o <= 1'b1;
         end
         if (state_ff == st_done) begin
            done_o   <= 1'b1;
            result_o <= rdata_ff;
            case (req_ff.kind)
               nand_prot_pkg::op_lock_query:
                  // only the four documented codes are valid
                  error_o <= !(rdata_ff[`LOCK_FIELD_MSB:0] == 3'h1
                            || rdata_ff[`LOCK_FIELD_MSB:0] == 3'h2
                            || rdata_ff[`LOCK_FIELD_MSB:0] == 3'h5
                            || rdata_ff[`LOCK_FIELD_MSB:0] == 3'h6);
               default:
                  error_o <= rdata_ff[`ST_FAIL_BIT];
            endcase
         end
      end
   end
   // ==========================================================
   // checks
   chk_wp_released: assert property (@(posedge clock_i) disable iff (srst_i)
      (state_ff == st_low) |-> wp_n_o)
      else $error("write-protect low during a bus cycle");
   chk_read_no_drive: assert property (@(posedge clock_i)
      disable iff (srst_i)
      !ctl_o.read_strobe_n |-> !io_oe_o)
      else $error("driving io while reading");
   chk_otp_range: assert property (@(posedge clock_i) disable iff (srst_i)
      (state_ff != st_idle && req_ff.kind == nand_prot_pkg::op_otp_prog)
      |-> (req_ff.arg0 >= `OTP_PAGE_FIRST && req_ff.arg0 <= `OTP_PAGE_LAST))
      else $error("otp page out of range");
   chk_group_range: assert property (@(posedge clock_i) disable iff (srst_i)
      (state_ff != st_idle && req_ff.kind == nand_prot_pkg::op_perm_prot)
      |-> req_ff.arg0[3:0] <= `GROUP_LAST)
      else $error("protect group out of range");
   chk_partial_max: assert property (@(posedge clock_i) disable iff (srst_i)
      part_cnt_ff <= `OTP_PARTIAL_MAX)
      else $error("too many partial programs");
   chk_done_pulse: assert property (@(posedge clock_i) disable iff (srst_i)
      done_o |=> !done_o)
      else $error("done longer than one cycle");
   chk_enable_seq: assert property (@(posedge clock_i) disable iff (srst_i)
      (req_ff.kind == nand_prot_pkg::op_perm_prot && state_ff == st_low
       && step_ff < 4'h4) |=> (ctl_o.cle && !ctl_o.ale && !ctl_o.we_n))
      else $error("stray cycle inside enable sequence");
   chk_query_invert: assert property (@(posedge clock_i) disable iff (srst_i)
      (req_ff.kind == nand_prot_pkg::op_lock_query && step_ff == 4'h1
       && state_ff == st_low) |=> (ctl_o.ale && !io_o[0]))
      else $error("invert bit set in lock query");
   cov_protect: cover property (@(posedge clock_i) disable iff (srst_i)
      state_ff == st_done && req_ff.kind == nand_prot_pkg::op_perm_prot);
   cov_otp_prog: cover property (@(posedge clock_i) disable iff (srst_i)
      state_ff == st_done && req_ff.kind == nand_prot_pkg::op_otp_prog);
   cov_query: cover property (@(posedge clock_i) disable iff (srst_i)
      state_ff == st_done && req_ff.kind == nand_prot_pkg::op_lock_query);
   cov_otp_locked: cover property (@(posedge clock_i) disable iff (srst_i)
      state_ff == st_done && req_ff.kind == nand_prot_pkg::op_otp_prog
      && otp_lock_ff);
endmodule : nand_prot_host

// ===== verif/flash_model.sv
// behavioural flash model: lock status, group protect and otp area
// assumes host strobes are registered on the clock given to this model
module flash_model #(
   parameter int PROG_BUSY  = 20,  // program busy time, cycles
   parameter int SHORT_BUSY = 3    // refused, feature and reset busy
) (
   input  wire logic                     clock_i,
   input  wire nand_prot_pkg::nand_ctl_t ctl_i,
   input  wire logic [7:0]               io_i,
   input  wire logic                     wp_n_i,
   input  wire logic                     fail_i,      // force group protect fail while high
   output logic [7:0]                    io_o,
   output logic                          rb_n_o,
   output logic                          proto_err_o  // host broke a rule
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // state
   logic        we_q;               // write strobe one cycle ago
   logic [7:0]  cmd;                // last command byte
   logic [7:0]  addr [0:4];         // address cycles of the command
   logic [7:0]  p1;                 // first feature parameter
   logic [7:0]  data;               // last data byte
   logic [7:0]  mem [0:31][0:255];  // otp area, low column byte only
   logic [2:0]  parts [0:31];       // partial programs per page
   logic [2:0]  acnt, pcnt, en_cnt; // cycle counters
   logic [11:0] groups;             // nonvolatile, never cleared
   logic [7:0]  mode;               // otp mode parameter
   logic [4:0]  last_pg;            // last otp page programmed
   logic        arm, otp_lock, fail_st, rd_lock;
   logic [2:0]  code;               // lock code of queried block
   logic [7:0]  rd_b;               // byte offered on read strobe
   logic [4:0]  pg;
   logic        wr, ok_p, ok_z, ok_o;
   int          busy;
   assign pg = addr[2][4:0];
   assign wr = !we_q && ctl_i.we_n && !ctl_i.ce_n;  // strobe rising
   assign ok_p = wp_n_i && !fail_i && addr[3][3:0] <= 4'hB;
   assign ok_z = {addr[0], addr[1], addr[2], addr[3], data} == 40'h0;
   assign ok_o = addr[2] >= 8'h02 && addr[2] <= 8'h1F && parts[pg] < 3'h4;
   assign rb_n_o = busy == 0;
   assign rd_b = rd_lock ? {5'h00, code} :
                 {wp_n_i, 1'b1, busy == 0, 4'h0, fail_st};
   // not read: inverse of the byte so a stale value never matches
   assign io_o = (!ctl_i.read_strobe_n && !ctl_i.ce_n) ? rd_b : ~rd_b;
   function automatic logic [7:0] en_byte(input logic [2:0] k);
      case (k)
         3'h0: return 8'h4C;
         3'h1: return 8'h03;
         3'h2: return 8'h1D;
         default: return 8'h41;
      endcase
   endfunction : en_byte
   // lock code picked by block bits; block high FF gives a bad code
   always_comb begin
      case (addr[0][7:6])
         2'h0: code = 3'h1;
         2'h1: code = 3'h2;
         2'h2: code = 3'h5;
         default: code = 3'h6;
      endcase
      if (addr[1] == 8'hFF)
         code = 3'h7;
   end
   // power-on contents: otp erased, nothing protected
   initial begin
      foreach (mem[i, j]) mem[i][j] = 8'hFF;
      foreach (parts[i]) parts[i] = 3'h0;
      foreach (addr[i]) addr[i] = 8'h00;
      {arm, otp_lock, fail_st, rd_lock, proto_err_o} = '0;
      {cmd, p1, data, mode, groups, last_pg} = '0;
      {acnt, pcnt, en_cnt} = '0;
      we_q = 1'b1;
      busy = 0;
   end
   // ==========================================================
   // bus decode on each rising write strobe
   always @(posedge clock_i) begin
      we_q <= ctl_i.we_n;
      if (busy > 0)
         busy <= busy - 1;
      if (wr && ctl_i.cle) begin
         cmd <= io_i;
         acnt <= 3'h0;
         pcnt <= 3'h0;
         en_cnt <= (en_cnt < 3'h4 && io_i == en_byte(en_cnt)) ?
                   en_cnt + 3'h1 : {2'h0, io_i == 8'h4C};
         arm <= en_cnt == 3'h4 && io_i == 8'h80;
         if (io_i == 8'h7A || io_i == 8'h70)
            rd_lock <= io_i == 8'h7A;
         if (io_i == 8'hFF)
            busy <= SHORT_BUSY;
         if (io_i == 8'h10 && arm) begin
            if (ok_p)
               groups[addr[3][3:0]] <= 1'b1;
            fail_st <= !ok_p;
            busy <= PROG_BUSY;
         end else if (io_i == 8'h10 && mode == 8'h03) begin
            otp_lock <= otp_lock | ok_z;
            fail_st <= !ok_z;
            busy <= PROG_BUSY;
         end else if (io_i == 8'h10 && mode == 8'h01 && otp_lock) begin
            fail_st <= 1'b1;
            busy <= SHORT_BUSY;
         end else if (io_i == 8'h10 && mode == 8'h01) begin
            if (!ok_o || pg < last_pg)
               proto_err_o <= 1'b1;
            if (ok_o) begin
               mem[pg][addr[0]] <= mem[pg][addr[0]] & data;
               parts[pg] <= parts[pg] + 3'h1;
               last_pg <= pg;
            end
            fail_st <= !ok_o;
            busy <= PROG_BUSY;
         end
      end else if (wr && ctl_i.ale) begin
         addr[acnt] <= io_i;
         acnt <= acnt + 3'h1;
         en_cnt <= 3'h0;
         if (cmd == 8'h7A && acnt == 3'h0 && io_i[0])
            proto_err_o <= 1'b1;
      end else if (wr) begin
         en_cnt <= 3'h0;
         data <= io_i;
         pcnt <= pcnt + 3'h1;
         if (cmd == 8'hEF && pcnt == 3'h0)
            p1 <= io_i;
         if (cmd == 8'hEF && pcnt == 3'h3 && addr[0] == 8'h90) begin
            mode <= p1;
            busy <= SHORT_BUSY;
         end
      end
   end
endmodule : flash_model

// ===== verif/tb_top.sv
// self-checking bench for the protection/otp host controller
// assumes flash_model stands on the far side of the flash pins
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      nand_prot_pkg::nand_req_t req;  // request
      logic       err;                // expected error flag
      logic       chk;                // compare the result byte
      logic [7:0] res;                // expected result byte
   } row_t;
   localparam int LIMIT = 20000;  // cycles; run needs about 1000
   logic clock_i, srst_i, req_valid_i, fail_inj;
   logic req_ready, done, err_o, io_oe, rb_n, wp_n, perr;
   logic [7:0] result, io_w, io_r;
   nand_prot_pkg::nand_req_t req_i;
   nand_prot_pkg::nand_ctl_t ctl;
   int errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   // kind, arg0, arg1, data, err, chk, result
   row_t rows [16] = '{
      {3'h0, 8'h00, 8'h00, 8'h00, 2'b01, 8'h01},
      {3'h0, 8'h40, 8'h00, 8'h00, 2'b01, 8'h02},
      {3'h0, 8'h80, 8'h00, 8'h00, 2'b01, 8'h05},
      {3'h0, 8'hC0, 8'h00, 8'h00, 2'b01, 8'h06},
      {3'h0, 8'h00, 8'hFF, 8'h00, 2'b11, 8'h07},
      {3'h1, 8'h05, 8'h00, 8'h00, 2'b01, 8'hE0},
      {3'h1, 8'h0B, 8'h00, 8'h00, 2'b01, 8'hE0},
      {3'h1, 8'h0C, 8'h00, 8'h00, 2'b10, 8'h00},
      {3'h2, 8'h01, 8'h00, 8'h00, 2'b00, 8'h00},
      {3'h3, 8'h02, 8'h10, 8'hA5, 2'b00, 8'h00},
      {3'h3, 8'h02, 8'h11, 8'h3C, 2'b00, 8'h00},
      {3'h3, 8'h03, 8'h00, 8'h0F, 2'b00, 8'h00},
      {3'h3, 8'h02, 8'h00, 8'h00, 2'b10, 8'h00},
      {3'h3, 8'h01, 8'h00, 8'h00, 2'b10, 8'h00},
      {3'h3, 8'h20, 8'h00, 8'h00, 2'b10, 8'h00},
      {3'h5, 8'h00, 8'h00, 8'h00, 2'b01, 8'hE0}
   };
   nand_prot_host u_dut (.clock_i(clock_i), .srst_i(srst_i), .req_i(req_i),
      .req_valid_i(req_valid_i), .req_ready_o(req_ready), .done_o(done),
      .result_o(result), .error_o(err_o), .ctl_o(ctl), .io_o(io_w),
      .io_oe_o(io_oe), .io_i(io_r), .rb_n_i(rb_n), .wp_n_o(wp_n));
   flash_model u_flash (.clock_i(clock_i), .ctl_i(ctl), .io_i(io_w),
      .wp_n_i(wp_n), .fail_i(fail_inj), .io_o(io_r), .rb_n_o(rb_n),
      .proto_err_o(perr));
   // ==========================================================
   // clock, watchdog and helpers
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   // a hang counts as a mismatch and still reaches the verdict
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         errors++;
         $display("MISMATCH timeout expected done seen hang");
         report_and_stop();
      end
   end
   task automatic check_bit(input string n, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %b seen %b", n, e, g);
      end
   endtask : check_bit
   task automatic check_byte(input string n, input logic [7:0] e,
                             input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : check_byte
   // one request, held for one edge, then wait for the done pulse
   task automatic do_op(input nand_prot_pkg::nand_req_t r);
      int k;
      logic got;
      k = 0;
      @(negedge clock_i);
      while (req_ready !== 1'b1)
         @(negedge clock_i);
      req_i = r;
      req_valid_i = 1'b1;
      // a refusal pulses done at the accepting edge itself
      @(posedge clock_i);
      #1;
      got = done;
      @(negedge clock_i);
      req_valid_i = 1'b0;
      while (got !== 1'b1 && k < 3000) begin
         @(posedge clock_i);
         #1;
         k++;
         got = done;
      end
      check_bit("done", 1'b1, got);
   endtask : do_op
   task automatic report_and_stop();
      $display("comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop
   // ==========================================================
   // main sequence
   initial begin
      srst_i = 1'b1;
      req_valid_i = 1'b0;
      req_i = '0;
      fail_inj = 1'b0;
      repeat (10) @(negedge clock_i);
      check_bit("ce_n", 1'b1, ctl.ce_n);
      check_bit("wp_n", 1'b0, wp_n);
      check_bit("io_oe", 1'b0, io_oe);
      repeat (10) @(negedge clock_i);
      srst_i = 1'b0;
      @(posedge clock_i);
      #1;
      check_bit("wp_n", 1'b1, wp_n);
      foreach (rows[i]) begin
         do_op(rows[i].req);
         check_bit("error", rows[i].err, err_o);
         if (rows[i].chk)
            check_byte("result", rows[i].res, result);
      end
      // two partials share a byte, fifth partial refused
      for (int i = 0; i < 5; i++) begin
         do_op({3'h3, 8'h04, 8'(i >> 1), i[0] ? 8'h3C : 8'hF0});
         check_bit("partial", i == 4, err_o);
      end
      check_byte("otp", 8'h30, u_flash.mem[4][1]);
      check_byte("otp", 8'hFF, u_flash.mem[4][2]);
      check_byte("otp", 8'hA5, u_flash.mem[2][16]);
      do_op({3'h2, 8'h00, 8'h00, 8'h00});
      check_byte("mode", 8'h00, u_flash.mode);
      fail_inj = 1'b1;
      do_op({3'h1, 8'h03, 8'h00, 8'h00});
      fail_inj = 1'b0;
      check_byte("status", 8'hE1, result);
      check_bit("error", 1'b1, err_o);
      check_byte("grp", 8'h20, u_flash.groups[7:0]);
      check_byte("grp", 8'h08, {4'h0, u_flash.groups[11:8]});
      do_op({3'h2, 8'h03, 8'h00, 8'h00});
      do_op({3'h4, 8'h00, 8'h00, 8'h01});
      check_bit("lock", 1'b1, err_o);
      do_op({3'h4, 8'h00, 8'h00, 8'h00});
      check_bit("lock", 1'b1, u_flash.otp_lock);
      do_op({3'h2, 8'h01, 8'h00, 8'h00});
      do_op({3'h3, 8'h06, 8'h00, 8'h00});
      check_bit("error", 1'b1, err_o);
      check_byte("otp", 8'hFF, u_flash.mem[6][0]);
      check_bit("proto", 1'b0, perr);
      report_and_stop();
   end
endmodule : tb_top
